//--- rtl/tlrb_pkg.sv
/*
  Shared constants and carrier types for the temperature limit register bank:
  register byte addresses, field positions, reset values and the packed
  structs that carry channel readings and the bank's whole state.
  Assumes an 8-bit register address space reached through a serial
  management interface whose framing is decoded outside this bank.
*/
package tlrb_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned EXT_CHANNELS = 4;
  localparam int unsigned ALL_CHANNELS = 5;
  localparam int unsigned FRAC_WIDTH = 3;
  localparam int unsigned READING_WIDTH = 11;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG_A = 8'h03;
  localparam logic [7:0] ADDR_CFG_B = 8'h09;
  localparam logic [7:0] ADDR_RATE_A = 8'h04;
  localparam logic [7:0] ADDR_RATE_B = 8'h0A;
  localparam logic [7:0] ADDR_INT_HIGH_A = 8'h05;
  localparam logic [7:0] ADDR_INT_HIGH_B = 8'h0B;
  localparam logic [7:0] ADDR_INT_LOW_A = 8'h06;
  localparam logic [7:0] ADDR_INT_LOW_B = 8'h0C;
  localparam logic [7:0] ADDR_EXT_HIGH_WHOLE_07 = 8'h07;
  localparam logic [7:0] ADDR_EXT_HIGH_WHOLE_0D = 8'h0D;
  localparam logic [7:0] ADDR_EXT_HIGH_WHOLE_15 = 8'h15;
  localparam logic [7:0] ADDR_EXT_HIGH_WHOLE_2C = 8'h2C;
  localparam logic [7:0] ADDR_EXT_HIGH_WHOLE_34 = 8'h34;
  localparam logic [7:0] ADDR_EXT_LOW_WHOLE_08 = 8'h08;
  localparam logic [7:0] ADDR_EXT_LOW_WHOLE_0E = 8'h0E;
  localparam logic [7:0] ADDR_EXT_LOW_WHOLE_16 = 8'h16;
  localparam logic [7:0] ADDR_EXT_LOW_WHOLE_2D = 8'h2D;
  localparam logic [7:0] ADDR_EXT_LOW_WHOLE_35 = 8'h35;
  localparam logic [7:0] ADDR_EXT_HIGH_FRAC_13 = 8'h13;
  localparam logic [7:0] ADDR_EXT_HIGH_FRAC_17 = 8'h17;
  localparam logic [7:0] ADDR_EXT_HIGH_FRAC_2E = 8'h2E;
  localparam logic [7:0] ADDR_EXT_HIGH_FRAC_36 = 8'h36;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_RANGE_BIT = 2;
  localparam int unsigned CFG_APD_BIT = 0;
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned RATE_WIDTH = 4;
  localparam int unsigned FRAC_LSB = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_RATE = 4'h0;
  localparam logic [2:0] RESET_FRAC = 3'h0;
  localparam logic [2:0] ZERO_FRAC = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // slot 0 is the internal diode, slots 1..4 the remote channels;
  // each reading is whole byte over a three-bit eighth-degree fraction
  typedef struct packed {
    logic valid;
    logic [ALL_CHANNELS-1:0][READING_WIDTH-1:0] reading;
  } tlrb_temp_type;

  typedef struct packed {
    logic [3:0] update_rate_code;
    logic range_offset;
    logic antiparallel_disable;
    logic [7:0] internal_upper_bound;
    logic [7:0] internal_lower_bound;
    logic [EXT_CHANNELS-1:0][7:0] remote_upper_bound_whole;
    logic [EXT_CHANNELS-1:0][2:0] remote_upper_bound_fraction;
    logic [EXT_CHANNELS-1:0][7:0] remote_lower_bound_whole;
    logic [7:0] rdata;
    logic rvalid;
    logic [ALL_CHANNELS-1:0] high_flag;
    logic [ALL_CHANNELS-1:0] low_flag;
    logic [1:0] pair_dual;
  } tlrb_state_type;

endpackage : tlrb_pkg

//--- rtl/tlrb_top.sv
/*
  Limit and rate register bank of a five-channel temperature monitor, with
  the limit comparison that turns each fresh reading into high/low flags.
  Assumes the serial management engine outside hands over one decoded
  byte access per strobe, and the conversion engine presents all readings
  together with a one-cycle valid, both synchronous to I_REF_CLK.
*/
`timescale 1ns/1ps

module tlrb_top (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire tlrb_pkg::tlrb_temp_type I_TEMP,
  output logic [7:0] O_RDATA,
  output logic O_RDATA_VALID,
  output logic [3:0] O_UPDATE_RATE_CODE,
  output logic O_RANGE_OFFSET,
  output logic [1:0] O_PAIR_DUAL,
  output logic [4:0] O_HIGH_FLAG,
  output logic [4:0] O_LOW_FLAG
);
  import tlrb_pkg::*;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  // returns {hit, slot} for the remote whole/fraction bytes; kind 0 is
  // upper whole, 1 lower whole, 2 upper fraction
  function automatic logic [2:0] ext_slot(input logic [7:0] a, input logic [1:0] kind);
    logic [2:0] r;
    r = 3'h0;
    case (kind)
      2'h0: begin
        case (a)
          ADDR_EXT_HIGH_WHOLE_07, ADDR_EXT_HIGH_WHOLE_0D: r = 3'h4;
          ADDR_EXT_HIGH_WHOLE_15: r = 3'h5;
          ADDR_EXT_HIGH_WHOLE_2C: r = 3'h6;
          ADDR_EXT_HIGH_WHOLE_34: r = 3'h7;
          default: r = 3'h0;
        endcase
      end
      2'h1: begin
        case (a)
          ADDR_EXT_LOW_WHOLE_08, ADDR_EXT_LOW_WHOLE_0E: r = 3'h4;
          ADDR_EXT_LOW_WHOLE_16: r = 3'h5;
          ADDR_EXT_LOW_WHOLE_2D: r = 3'h6;
          ADDR_EXT_LOW_WHOLE_35: r = 3'h7;
          default: r = 3'h0;
        endcase
      end
      2'h2: begin
        case (a)
          ADDR_EXT_HIGH_FRAC_13: r = 3'h4;
          ADDR_EXT_HIGH_FRAC_17: r = 3'h5;
          ADDR_EXT_HIGH_FRAC_2E: r = 3'h6;
          ADDR_EXT_HIGH_FRAC_36: r = 3'h7;
          default: r = 3'h0;
        endcase
      end
      default: r = 3'h0;
    endcase
    return r;
  endfunction : ext_slot

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tlrb_state_type st_reg;
  tlrb_state_type st_next;
  logic [ALL_CHANNELS-1:0][READING_WIDTH-1:0] upper_limit;
  logic [ALL_CHANNELS-1:0][READING_WIDTH-1:0] lower_limit;
  logic [ALL_CHANNELS-1:0] above_upper;
  logic [ALL_CHANNELS-1:0] at_or_below_lower;
  logic [2:0] hi_slot;
  logic [2:0] lo_slot;
  logic [2:0] fr_slot;

  assign hi_slot = ext_slot(I_ADDR, 2'h0);
  assign lo_slot = ext_slot(I_ADDR, 2'h1);
  assign fr_slot = ext_slot(I_ADDR, 2'h2);

  // ---------------------------------------------------------------
  // limit comparison
  // ---------------------------------------------------------------
  // offset binary is monotonic like plain binary, so one unsigned compare
  // serves both ranges as long as readings and limits share the format
  assign upper_limit[0] = {st_reg.internal_upper_bound, ZERO_FRAC};
  assign lower_limit[0] = {st_reg.internal_lower_bound, ZERO_FRAC};
  genvar gc;
  generate
    for (gc = 0; gc < EXT_CHANNELS; gc++) begin : g_ext
      assign upper_limit[gc+1] = {st_reg.remote_upper_bound_whole[gc],
                                  st_reg.remote_upper_bound_fraction[gc]};
      // lower fraction bytes are not held here, so the lower bound is whole
      assign lower_limit[gc+1] = {st_reg.remote_lower_bound_whole[gc], ZERO_FRAC};
    end
    for (gc = 0; gc < ALL_CHANNELS; gc++) begin : g_cmp
      assign above_upper[gc] = I_TEMP.reading[gc] > upper_limit[gc];
      assign at_or_below_lower[gc] = I_TEMP.reading[gc] <= lower_limit[gc];
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = I_RD_EN;
    if (I_RD_EN) begin
      st_next.rdata = UNMAPPED_READ;
      case (I_ADDR)
        ADDR_CFG_A, ADDR_CFG_B: begin
          st_next.rdata[CFG_RANGE_BIT] = st_reg.range_offset;
          st_next.rdata[CFG_APD_BIT] = st_reg.antiparallel_disable;
        end
        ADDR_RATE_A, ADDR_RATE_B: begin
          st_next.rdata[RATE_LSB +: RATE_WIDTH] = st_reg.update_rate_code;
        end
        ADDR_INT_HIGH_A, ADDR_INT_HIGH_B: st_next.rdata = st_reg.internal_upper_bound;
        ADDR_INT_LOW_A, ADDR_INT_LOW_B: st_next.rdata = st_reg.internal_lower_bound;
        default: begin
          if (hi_slot[2]) begin
            st_next.rdata = st_reg.remote_upper_bound_whole[hi_slot[1:0]];
          end else if (lo_slot[2]) begin
            st_next.rdata = st_reg.remote_lower_bound_whole[lo_slot[1:0]];
          end else if (fr_slot[2]) begin
            st_next.rdata[FRAC_LSB +: FRAC_WIDTH] =
              st_reg.remote_upper_bound_fraction[fr_slot[1:0]];
          end
        end
      endcase
    end
    // every alias decodes onto the same field, so no copy can go stale
    if (I_WR_EN) begin
      case (I_ADDR)
        ADDR_CFG_A, ADDR_CFG_B: begin
          st_next.range_offset = I_WDATA[CFG_RANGE_BIT];
          st_next.antiparallel_disable = I_WDATA[CFG_APD_BIT];
        end
        ADDR_RATE_A, ADDR_RATE_B: begin
          st_next.update_rate_code = I_WDATA[RATE_LSB +: RATE_WIDTH];
        end
        ADDR_INT_HIGH_A, ADDR_INT_HIGH_B: st_next.internal_upper_bound = I_WDATA;
        ADDR_INT_LOW_A, ADDR_INT_LOW_B: st_next.internal_lower_bound = I_WDATA;
        default: begin
          if (hi_slot[2]) begin
            st_next.remote_upper_bound_whole[hi_slot[1:0]] = I_WDATA;
          end else if (lo_slot[2]) begin
            st_next.remote_lower_bound_whole[lo_slot[1:0]] = I_WDATA;
          end else if (fr_slot[2]) begin
            st_next.remote_upper_bound_fraction[fr_slot[1:0]] =
              I_WDATA[FRAC_LSB +: FRAC_WIDTH];
          end
        end
      endcase
    end
    // flags follow each fresh set of readings and hold between them
    if (I_TEMP.valid) begin
      st_next.high_flag = above_upper;
      st_next.low_flag = at_or_below_lower;
    end
    // each bit tells the bias stage whether its pair carries two diodes
    st_next.pair_dual = {2{~st_reg.antiparallel_disable}};
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_reg <= '0;
      st_reg.update_rate_code <= RESET_RATE;
      st_reg.internal_upper_bound <= RESET_BYTE;
      st_reg.internal_lower_bound <= RESET_BYTE;
      st_reg.remote_upper_bound_whole <= {EXT_CHANNELS{RESET_BYTE}};
      st_reg.remote_upper_bound_fraction <= {EXT_CHANNELS{RESET_FRAC}};
      st_reg.remote_lower_bound_whole <= {EXT_CHANNELS{RESET_BYTE}};
      st_reg.pair_dual <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // the conversion engine reads the code straight off this port
  assign O_UPDATE_RATE_CODE = st_reg.update_rate_code;
  assign O_RANGE_OFFSET = st_reg.range_offset;
  assign O_RDATA = st_reg.rdata;
  assign O_RDATA_VALID = st_reg.rvalid;
  assign O_PAIR_DUAL = st_reg.pair_dual;
  assign O_HIGH_FLAG = st_reg.high_flag;
  assign O_LOW_FLAG = st_reg.low_flag;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);

  // ---------------------------------------------------------------
  // checks: alias storage and fraction read-back
  // ---------------------------------------------------------------
  // the host leaves one idle cycle between a write and its read-back;
  // a write in that gap may legally change the value, so it is excluded
  rate_alias_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_RATE_A) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_RATE_B) |=> O_RDATA[3:0] == $past(I_WDATA[3:0], 3))
    else $error("rate code not seen through second address");
  high_alias_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_INT_HIGH_B) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_INT_HIGH_A) |=> O_RDATA == $past(I_WDATA, 3))
    else $error("internal high limit alias mismatch");
  low_alias_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_INT_LOW_A) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_INT_LOW_B) |=> O_RDATA == $past(I_WDATA, 3))
    else $error("internal low limit alias mismatch");
  ext_high_alias_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_EXT_HIGH_WHOLE_07) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_EXT_HIGH_WHOLE_0D) |=> O_RDATA == $past(I_WDATA, 3))
    else $error("remote high whole alias mismatch");
  ext_low_alias_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_EXT_LOW_WHOLE_0E) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_EXT_LOW_WHOLE_08) |=> O_RDATA == $past(I_WDATA, 3))
    else $error("remote low whole alias mismatch");
  frac_value_a: assert property (
    (I_WR_EN && I_ADDR == ADDR_EXT_HIGH_FRAC_17) ##1 !I_WR_EN ##1
    (I_RD_EN && I_ADDR == ADDR_EXT_HIGH_FRAC_17)
    |=> O_RDATA[FRAC_LSB +: FRAC_WIDTH] == $past(I_WDATA[FRAC_LSB +: FRAC_WIDTH], 3))
    else $error("fraction bits not read back");

  // ---------------------------------------------------------------
  // checks: configuration outputs
  // ---------------------------------------------------------------
  rate_out_a: assert property (
    I_WR_EN && (I_ADDR == ADDR_RATE_A || I_ADDR == ADDR_RATE_B)
    |=> O_UPDATE_RATE_CODE == $past(I_WDATA[RATE_LSB +: RATE_WIDTH]))
    else $error("exported rate code does not follow the write");
  range_out_a: assert property (
    I_WR_EN && (I_ADDR == ADDR_CFG_A || I_ADDR == ADDR_CFG_B)
    |=> O_RANGE_OFFSET == $past(I_WDATA[CFG_RANGE_BIT]))
    else $error("range output does not follow the write");
  single_diode_a: assert property (
    st_reg.antiparallel_disable |=> O_PAIR_DUAL == 2'h0)
    else $error("pairs still dual with disable set");
  dual_diode_a: assert property (
    !st_reg.antiparallel_disable |=> O_PAIR_DUAL == 2'h3)
    else $error("pairs not dual with disable clear");

  // ---------------------------------------------------------------
  // checks: limit flags
  // ---------------------------------------------------------------
  int_high_flag_a: assert property (
    I_TEMP.valid && I_TEMP.reading[0] > {st_reg.internal_upper_bound, ZERO_FRAC}
    |=> O_HIGH_FLAG[0])
    else $error("internal high flag missed");
  int_low_flag_a: assert property (
    I_TEMP.valid && I_TEMP.reading[0] <= {st_reg.internal_lower_bound, ZERO_FRAC}
    |=> O_LOW_FLAG[0])
    else $error("internal low flag missed");
  ext_high_flag_a: assert property (
    I_TEMP.valid && I_TEMP.reading[1] >
    {st_reg.remote_upper_bound_whole[0], st_reg.remote_upper_bound_fraction[0]}
    |=> O_HIGH_FLAG[1])
    else $error("remote high flag missed");
  ext_low_flag_a: assert property (
    I_TEMP.valid && I_TEMP.reading[1] == {st_reg.remote_lower_bound_whole[0], ZERO_FRAC}
    |=> O_LOW_FLAG[1])
    else $error("equal to low limit did not flag");
  frac_edge_a: assert property (
    I_TEMP.valid && I_TEMP.reading[1] ==
    {st_reg.remote_upper_bound_whole[0], st_reg.remote_upper_bound_fraction[0]}
    |=> !O_HIGH_FLAG[1])
    else $error("reading equal to fractional high limit flagged");
  flag_hold_a: assert property (
    !I_TEMP.valid |=> $stable(O_HIGH_FLAG) && $stable(O_LOW_FLAG))
    else $error("flags moved without a fresh reading");

  // ---------------------------------------------------------------
  // checks: read port
  // ---------------------------------------------------------------
  frac_bits_a: assert property (
    I_RD_EN && I_ADDR == ADDR_EXT_HIGH_FRAC_13
    |=> O_RDATA[4:0] == 5'h00 && O_RDATA_VALID)
    else $error("fraction byte low bits not zero");
  read_valid_a: assert property (
    O_RDATA_VALID == $past(I_RD_EN))
    else $error("read valid not one cycle after strobe");
  rdata_hold_a: assert property (
    !I_RD_EN |=> $stable(O_RDATA))
    else $error("read data moved without a read");

endmodule : tlrb_top

//--- verif/tlrb_host_model.sv
/*
  Host-side model of the temperature limit register bank: issues decoded
  byte writes and reads and presents sample beats of all five readings.
  Assumes one clock shared with the bank; all strobes change on the
  falling edge and stand for exactly one rising edge.
*/
`timescale 1ns/1ps

module tlrb_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output tlrb_pkg::tlrb_temp_type o_temp
);
  import tlrb_pkg::*;

  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_temp = '0;
  end

  // ---------------------------------------------------------------
  // byte accesses
  // ---------------------------------------------------------------
  // released lines flip to the inverse so stale values never look valid
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  // answer is registered at the taking edge and sampled half a cycle later, on the falling edge
  task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rdata_valid;
  endtask : rd

  // ---------------------------------------------------------------
  // sample beats
  // ---------------------------------------------------------------
  task put_temp(input logic [ALL_CHANNELS-1:0][READING_WIDTH-1:0] r);
    @(negedge i_clk);
    o_temp.valid = 1'b1;
    o_temp.reading = r;
    @(posedge i_clk);
    @(negedge i_clk);
    o_temp.valid = 1'b0;
    o_temp.reading = ~r;
  endtask : put_temp

endmodule : tlrb_host_model

//--- verif/tb.sv
/*
  Self-checking bench for the limit register bank: reset values, alias
  storage, masked fields, configuration outputs and limit comparison.
  Assumes the host model drives every bank input except clock and reset, which the bench drives; nothing is tied off.
*/
`timescale 1ns/1ps

module tb;
  import tlrb_pkg::*;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en, rd_en, rdata_valid, range_offset;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] rate_code;
  logic [1:0] pair_dual;
  logic [4:0] high_flag, low_flag;
  tlrb_temp_type temp;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // stimulus tables
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LIST [22] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h15, 8'h16, 8'h17, 8'h2C,
    8'h2D, 8'h2E, 8'h34, 8'h35, 8'h36};
  // write address, read address, write data, expected read
  localparam logic [31:0] ALIAS_TBL [19] = '{32'h040AFF0F, 32'h0A040505,
    32'h050BA5A5, 32'h0B051E1E, 32'h060C5A5A, 32'h0C061010, 32'h070D8181,
    32'h0D072020, 32'h080E4242, 32'h0E080808, 32'h1313FFE0, 32'h13137F60,
    32'h1515C3C3, 32'h1717FFE0, 32'h16163C3C, 32'h2C2CFFFF, 32'h2E2EFFE0,
    32'h2D2D0101, 32'h01017700};

  always #50 clk = ~clk;

  tlrb_top tlrb_top_i (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_WR_EN(wr_en),
    .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata), .I_TEMP(temp),
    .O_RDATA(rdata), .O_RDATA_VALID(rdata_valid), .O_UPDATE_RATE_CODE(rate_code),
    .O_RANGE_OFFSET(range_offset), .O_PAIR_DUAL(pair_dual),
    .O_HIGH_FLAG(high_flag), .O_LOW_FLAG(low_flag));

  tlrb_host_model tlrb_host_model_i (.i_clk(clk), .i_rdata(rdata),
    .i_rdata_valid(rdata_valid), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata), .o_temp(temp));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk8

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    tlrb_host_model_i.rd(a, d, v);
    chk8("read valid", 8'h01, {7'h00, v});
    chk8($sformatf("read %h", a), exp, d);
  endtask : rd_chk

  task test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset();
    chk8("pair dual", 8'h03, {6'h00, pair_dual});
    chk8("rate out", 8'h00, {4'h0, rate_code});
    foreach (RST_LIST[i]) rd_chk(RST_LIST[i], 8'h00);
    $display("test reset done");
  endtask : t_reset

  // writes through one alias, reads through the other, or the same address for unaliased bytes; ends with unmapped
  task t_alias();
    foreach (ALIAS_TBL[i]) begin
      tlrb_host_model_i.wr(ALIAS_TBL[i][31:24], ALIAS_TBL[i][15:8]);
      rd_chk(ALIAS_TBL[i][23:16], ALIAS_TBL[i][7:0]);
    end
    chk8("rate out", 8'h05, {4'h0, rate_code});
    $display("test alias done");
  endtask : t_alias

  task t_config();
    tlrb_host_model_i.wr(8'h03, 8'hFF);
    rd_chk(8'h09, 8'h05);
    chk8("pair dual", 8'h00, {6'h00, pair_dual});
    chk8("range", 8'h01, {7'h00, range_offset});
    tlrb_host_model_i.wr(8'h09, 8'h00);
    rd_chk(8'h03, 8'h00);
    chk8("pair dual", 8'h03, {6'h00, pair_dual});
    chk8("range", 8'h00, {7'h00, range_offset});
    $display("test config done");
  endtask : t_config

  // limits from t_alias: int 1E/10, ch1 {20,3}/08, ch2 {C3,7}/3C, ch3 {FF,7}/01, ch4 0/0
  task t_flags();
    tlrb_host_model_i.put_temp({11'h000, 11'h001, 11'h61F, 11'h103, 11'h0F0});
    chk8("high flags", 8'h00, {3'h0, high_flag});
    chk8("low flags", 8'h18, {3'h0, low_flag});
    tlrb_host_model_i.put_temp({11'h000, 11'h000, 11'h000, 11'h040, 11'h080});
    chk8("high flags", 8'h00, {3'h0, high_flag});
    chk8("low flags", 8'h1F, {3'h0, low_flag});
    tlrb_host_model_i.put_temp({11'h001, 11'h010, 11'h1E0, 11'h104, 11'h0F1});
    chk8("high flags", 8'h13, {3'h0, high_flag});
    chk8("low flags", 8'h04, {3'h0, low_flag});
    $display("test flags done");
  endtask : t_flags

  // mid-run reset must bring written limits and raised flags back to zero
  task t_rearm();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk8("pair dual", 8'h03, {6'h00, pair_dual});
    chk8("rate out", 8'h00, {4'h0, rate_code});
    chk8("high flags", 8'h00, {3'h0, high_flag});
    chk8("low flags", 8'h00, {3'h0, low_flag});
    rd_chk(8'h0B, 8'h00);
    rd_chk(8'h0C, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h0A, 8'h00);
    $display("test rearm done");
  endtask : t_rearm

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  // ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_alias();
    t_config();
    t_flags();
    t_rearm();
    test_done();
  end

endmodule : tb
